// [src/ettc_defs.vh]
`ifndef ETTC_DEFS_VH
`define ETTC_DEFS_VH

////////////////////////////////////////////////////////////////////////
// register byte offsets, page zero of the bus window
`define ETTC_OFS_GATE   8'h00
`define ETTC_OFS_EN0    8'h04
`define ETTC_OFS_BASE   8'h18
`define ETTC_OFS_STAT   8'h1C

////////////////////////////////////////////////////////////////////////
// field positions
`define ETTC_GATE_BIT   3
`define ETTC_SZ_BIT     6
`define ETTC_CHN_BIT    4
`define ETTC_DST_BIT    3
`define ETTC_SRC_BIT    2
`define ETTC_MODE_BIT   0

////////////////////////////////////////////////////////////////////////
// reset values and sizes
`define ETTC_GATE_RST   8'h00
`define ETTC_EN_RST     40'h00_0000_0000
`define ETTC_BASE_RST   8'hFD
`define ETTC_NSRC       40
`define ETTC_SERIAL_SRC 11

`endif

// [src/ettc_cd_mem.v]
`timescale 1ns/1ps
// control data store: two words per set, eight sets
module ettc_cd_mem (
    // clock and reset
    input  wire        clock,
    input  wire        rstn,
    // single port
    input  wire        we,
    input  wire [3:0]  addr,
    input  wire [31:0] wdata,
    output reg  [31:0] rdata
);
    reg [31:0] mem [0:15];

    // array carries no reset, only the read register does
    always @(posedge clock) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    // registered read keeps one cycle latency for every user
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= mem[addr];
        end
    end
endmodule

// [src/ettc_top.v]
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "ettc_defs.vh"
// event triggered transfer controller with ahb-lite register slave
module ettc_top (
    // clock and reset
    input  wire        clock,
    input  wire        rstn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire [31:0] hrdata,
    output wire        hresp,
    // activation events, one-cycle pulses
    input  wire [39:0] evt,
    input  wire        serial_end,
    // data mover master port
    output wire        dm_req,
    output wire        dm_we,
    output wire        dm_size,
    output wire [15:0] dm_addr,
    output wire [15:0] dm_wdata,
    input  wire [15:0] dm_rdata,
    input  wire        dm_ack,
    // status
    output wire        busy
);
    // one-hot engine states; any other code falls back to idle
    localparam S_IDLE = 8'h01;
    localparam S_LD0  = 8'h02;
    localparam S_LD1  = 8'h04;
    localparam S_LD2  = 8'h08;
    localparam S_RD   = 8'h10;
    localparam S_WR   = 8'h20;
    localparam S_WB0  = 8'h40;
    localparam S_WB1  = 8'h80;

    // software visible registers
    reg  [7:0]  gate_q;
    reg  [39:0] en_q;
    reg  [7:0]  base_q;

    // activation and engine sequencing
    reg  [39:0] pend_q;
    reg  [7:0]  state_q;
    reg  [7:0]  state_d;
    reg  [5:0]  src_q;
    reg  [2:0]  set_q;
    reg         first_q;
    reg         zero_q;

    // working copy of the active control set
    reg  [7:0]  ctrl_q;
    reg  [7:0]  blk_q;
    reg  [7:0]  cnt_q;
    reg  [7:0]  rld_q;
    reg  [15:0] sptr_q;
    reg  [15:0] dptr_q;

    // unit counter and the unit in flight
    reg  [8:0]  left_q;
    reg  [15:0] data_q;

    // bus data phase bookkeeping
    reg         bph_q;
    reg         bdone_q;
    reg         awr_q;
    reg         ahi_q;
    reg  [15:0] aadr_q;
    reg  [31:0] rd_q;
    reg  [31:0] rd_d;

    // arbitration and memory read port
    reg  [5:0]  pick;
    reg         found;
    integer     k;
    wire [31:0] mem_rdata;

    ////////////////////////////////////////////////////////////////////
    // decode and qualifiers
    wire        gate_on  = gate_q[`ETTC_GATE_BIT];
    wire        idle     = (state_q == S_IDLE);

    // bus address decode: page zero holds the registers
    wire        b_reg    = ahi_q && (aadr_q[15:8] == 8'h00);
    wire        b_mem    = ahi_q && !b_reg && (aadr_q[15:8] == base_q)
                           && (aadr_q[7:6] == 2'b00);
    // limitation: a control-area access waits while a set is in flight,
    // and waits until the gate is back on if it was switched off mid-set
    wire        b_go     = bph_q && !(b_mem && !idle);
    wire        take     = hsel && hready && htrans[1];

    // activation sources and fields of the active control set
    wire [39:0] act_in   = evt | ({39'h0, serial_end} << `ETTC_SERIAL_SRC);
    wire        sz16     = ctrl_q[`ETTC_SZ_BIT];
    wire        chain    = ctrl_q[`ETTC_CHN_BIT];
    wire        repeat_m = ctrl_q[`ETTC_MODE_BIT];

    // pointer step and count update
    wire [15:0] step     = sz16 ? 16'h0002 : 16'h0001;
    wire [7:0]  cnt_dec  = cnt_q - 8'h01;
    wire [7:0]  cnt_nxt  = (cnt_dec == 8'h00 && repeat_m) ? rld_q : cnt_dec;

    // end of a chain, enable clear, and start of a new activation
    wire        fin      = (state_q == S_WB1) && gate_on && !chain;
    wire        clr_en   = (state_q == S_WB1) && gate_on && first_q && zero_q;
    wire        start    = idle && gate_on && found && !(bph_q && b_mem);

    ////////////////////////////////////////////////////////////////////
    // lowest numbered enabled pending source wins
    always @* begin
        pick  = 6'h00;
        found = 1'b0;
        // scan from the top so the lowest match is written last
        for (k = `ETTC_NSRC - 1; k >= 0; k = k - 1) begin
            if (pend_q[k] && en_q[k]) begin
                pick  = k[5:0];
                found = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pending flags; a new event beats the clear in the same cycle
    genvar g;
    generate
        for (g = 0; g < `ETTC_NSRC; g = g + 1) begin : g_pend
            // a source whose enable is off never latches, even mid-transfer
            wire set_p = gate_on && act_in[g] && en_q[g];
            wire clr_p = fin && (src_q == g);
            always @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    pend_q[g] <= 1'b0;
                end else begin
                    pend_q[g] <= set_p || (pend_q[g] && !clr_p);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // control data memory shared by engine and bus; engine owns it when busy
    // engine reads word0 in LD0, word1 in LD1; data lands a cycle later
    wire        eng_we   = (state_q == S_WB0 || state_q == S_WB1) && gate_on;
    wire        eng_word = (state_q == S_LD1 || state_q == S_WB1);
    wire [31:0] eng_wd   = (state_q == S_WB1) ? {dptr_q, sptr_q}
                                              : {rld_q, cnt_nxt, blk_q, ctrl_q};
    wire        bus_we   = b_go && b_mem && awr_q;
    wire        m_we     = idle ? bus_we : eng_we;
    wire [3:0]  m_addr   = idle ? aadr_q[5:2] : {set_q, eng_word};
    wire [31:0] m_wd     = idle ? hwdata : eng_wd;

    ettc_cd_mem u_mem (
        .clock (clock),
        .rstn  (rstn),
        .we    (m_we),
        .addr  (m_addr),
        .wdata (m_wd),
        .rdata (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // ahb-lite: every transfer takes at least one wait state in its data phase
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bph_q   <= 1'b0;
            bdone_q <= 1'b0;
            awr_q   <= 1'b0;
            ahi_q   <= 1'b0;
            aadr_q  <= 16'h0000;
            rd_q    <= 32'h0000_0000;
        end else begin
            bdone_q <= b_go;
            // data phase ends: release the wait and latch read data
            if (b_go) begin
                bph_q <= 1'b0;
                rd_q  <= rd_d;
            end
            // new address phase, accepted only with no wait pending
            if (take && !bph_q) begin
                bph_q  <= 1'b1;
                awr_q  <= hwrite;
                ahi_q  <= (haddr[31:16] == 16'h0000);
                aadr_q <= haddr[15:0];
            end
        end
    end

    // memory reads come straight from the store's read register
    assign hreadyout = !bph_q;
    assign hresp     = 1'b0;
    assign hrdata    = (bdone_q && b_mem) ? mem_rdata : rd_q;

    // register read mux; unmapped reads return zero
    always @* begin
        rd_d = 32'h0000_0000;
        if (b_reg && !awr_q) begin
            case (aadr_q[7:0])
                `ETTC_OFS_GATE: rd_d = {24'h0, gate_q};
                8'h04:          rd_d = {24'h0, en_q[7:0]};
                8'h08:          rd_d = {24'h0, en_q[15:8]};
                8'h0C:          rd_d = {24'h0, en_q[23:16]};
                8'h10:          rd_d = {24'h0, en_q[31:24]};
                8'h14:          rd_d = {24'h0, en_q[39:32]};
                `ETTC_OFS_BASE: rd_d = {24'h0, base_q};
                `ETTC_OFS_STAT: rd_d = {20'h0, !idle, set_q, 2'b00, src_q};
                default:        rd_d = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software registers; the engine may clear one enable bit
    wire       w_reg = b_go && b_reg && awr_q;
    wire [7:0] wofs  = aadr_q[7:0] - `ETTC_OFS_EN0;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            gate_q <= `ETTC_GATE_RST;
            en_q   <= `ETTC_EN_RST;
            base_q <= `ETTC_BASE_RST;
        end else begin
            if (w_reg && aadr_q[7:0] == `ETTC_OFS_GATE) begin
                gate_q <= hwdata[7:0];
            end
            if (w_reg && aadr_q[7:0] == `ETTC_OFS_BASE) begin
                base_q <= hwdata[7:0];
            end
            // enable registers sit at four byte steps from the first
            if (w_reg && wofs[1:0] == 2'b00 && wofs[7:2] < 6'd5) begin
                en_q[wofs[4:2]*8 +: 8] <= hwdata[7:0];
            end
            // hardware clear is applied last so a finished source stays off
            if (clr_en) begin
                en_q[src_q] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transfer engine; nothing advances while the clock gate is off
    always @* begin
        state_d = state_q;
        if (gate_on) begin
            case (state_q)
                S_IDLE: if (start) state_d = S_LD0;
                S_LD0:  state_d = S_LD1;
                S_LD1:  state_d = S_LD2;
                S_LD2:  state_d = S_RD;
                S_RD:   if (dm_ack) state_d = S_WR;
                S_WR: begin
                    if (dm_ack) state_d = (left_q == 9'd1) ? S_WB0 : S_RD;
                end
                S_WB0:  state_d = S_WB1;
                // a chained set loads at once, without a new event
                S_WB1:  state_d = chain ? S_LD0 : S_IDLE;
                default: state_d = S_IDLE;
            endcase
        end
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= S_IDLE;
            src_q   <= 6'h00;
            set_q   <= 3'h0;
            first_q <= 1'b0;
            zero_q  <= 1'b0;
            ctrl_q  <= 8'h00;
            blk_q   <= 8'h00;
            cnt_q   <= 8'h00;
            rld_q   <= 8'h00;
            sptr_q  <= 16'h0000;
            dptr_q  <= 16'h0000;
            left_q  <= 9'h000;
            data_q  <= 16'h0000;
        end else begin
            state_q <= state_d;

            // latch the winning source; its set follows from its number
            if (start) begin
                src_q   <= pick;
                set_q   <= pick[2:0];
                first_q <= 1'b1;
            end

            // word0 of the set: control, block, count, reload
            if (gate_on && state_q == S_LD1) begin
                ctrl_q <= mem_rdata[7:0];
                blk_q  <= mem_rdata[15:8];
                cnt_q  <= mem_rdata[23:16];
                rld_q  <= mem_rdata[31:24];
            end

            if (gate_on && state_q == S_LD2) begin
                sptr_q <= mem_rdata[15:0];
                dptr_q <= mem_rdata[31:16];
                // a block size of zero moves 256 units
                left_q <= (blk_q == 8'h00) ? 9'd256 : {1'b0, blk_q};
            end

            // read beat done: keep the unit for the write beat
            if (gate_on && state_q == S_RD && dm_ack) begin
                data_q <= sz16 ? dm_rdata : {8'h00, dm_rdata[7:0]};
            end

            // write beat done: count the unit and step each pointer whose increment bit is set
            if (gate_on && state_q == S_WR && dm_ack) begin
                left_q <= left_q - 9'd1;
                if (ctrl_q[`ETTC_SRC_BIT]) begin
                    sptr_q <= sptr_q + step;
                end
                if (ctrl_q[`ETTC_DST_BIT]) begin
                    dptr_q <= dptr_q + step;
                end
            end

            // count update is written back in the same cycle
            if (gate_on && state_q == S_WB0) begin
                cnt_q  <= cnt_nxt;
                zero_q <= (cnt_dec == 8'h00) && !repeat_m;
            end

            // a chained set is no longer the one tied to the source
            if (gate_on && state_q == S_WB1 && chain) begin
                set_q   <= set_q + 3'd1;
                first_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mover port; request drops while the gate is off
    assign dm_req   = gate_on && (state_q == S_RD || state_q == S_WR);
    // address and direction follow the state even while the request is withdrawn
    assign dm_we    = (state_q == S_WR);
    assign dm_size  = sz16;
    assign dm_addr  = (state_q == S_WR) ? dptr_q : sptr_q;
    assign dm_wdata = data_q;
    assign busy     = !idle;
endmodule

// [tb/ettc_props.sv]
`timescale 1ns/1ps
// watches the bus and mover pins of the controller
module ettc_props (
    // clock and reset
    input wire        clock,
    input wire        rstn,
    // ahb-lite slave
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire [31:0] hrdata,
    input wire        hresp,
    // events
    input wire [39:0] evt,
    input wire        serial_end,
    // mover
    input wire        dm_req,
    input wire        dm_we,
    input wire        dm_size,
    input wire [15:0] dm_addr,
    input wire [15:0] dm_wdata,
    input wire [15:0] dm_rdata,
    input wire        dm_ack,
    // status
    input wire        busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // request taken, read beat done
    wire take    = hsel && hready && htrans[1];
    wire rd_done = dm_req && !dm_we && dm_ack;
////////////////////////////////////////////////////////////////////////
    reg_wait_a: assert property (take && haddr[15:8] == 8'h00 |=> !hreadyout ##1 hreadyout)
        else $error("register wait not one cycle");
    ready_cause_a: assert property ($fell(hreadyout) |-> $past(take))
        else $error("wait cycle without a request");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    // beats must not change under the far side before ack
    req_hold_a: assert property (dm_req && !dm_ack |=> dm_req && $stable(dm_addr) && $stable(dm_we))
        else $error("beat changed before ack");
    fwd_data_a: assert property (rd_done |=> dm_req && dm_we && dm_wdata[7:0] == $past(dm_rdata[7:0]))
        else $error("read byte not forwarded");
    wide_data_a: assert property (rd_done && dm_size |=> dm_wdata == $past(dm_rdata))
        else $error("read word not forwarded");
    size_pair_a: assert property (rd_done |=> $stable(dm_size))
        else $error("write size differs from read");
    byte_pad_a: assert property (dm_req && dm_we && !dm_size |-> dm_wdata[15:8] == 8'h00)
        else $error("byte write upper half not zero");
    idle_quiet_a: assert property (!busy |-> !dm_req)
        else $error("request while idle");
    cover property (rd_done && dm_size);
    cover property (dm_req && dm_we && dm_ack);
    cover property ($fell(busy));
endmodule
bind ettc_top ettc_props ettc_props_i (.clock, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .evt, .serial_end, .dm_req, .dm_we, .dm_size, .dm_addr,
    .dm_wdata, .dm_rdata, .dm_ack, .busy);

// [tb/ettc_mover_model.sv]
`timescale 1ns/1ps
// memory side of the mover plus the serial channel's end event
module ettc_mover_model (
    // clock
    input wire        clock,
    // mover
    input wire        dm_req,
    input wire        dm_we,
    input wire [15:0] dm_addr,
    input wire [15:0] dm_wdata,
    output reg [15:0] dm_rdata,
    output reg        dm_ack,
    // serial channel
    output reg        serial_end
);
    logic [15:0] wa_q[$];
    logic [15:0] wd_q[$];
    int          wait_n = 0;
    bit          slow = 0;
    initial begin
        dm_rdata = 16'h0000;
        dm_ack = 1'b0;
        serial_end = 1'b0;
    end
    // prompt and slow answers by turns; read data toggles outside a read ack
    always @(posedge clock) begin
        dm_ack <= 1'b0;
        dm_rdata <= ~dm_rdata;
        if (dm_req && !dm_ack) begin
            if (wait_n < (slow ? 2 : 0)) begin
                wait_n <= wait_n + 1;
            end else begin
                dm_ack <= 1'b1;
                wait_n <= 0;
                slow <= !slow;
                if (dm_we) begin
                    wa_q.push_back(dm_addr);
                    wd_q.push_back(dm_wdata);
                end else begin
                    dm_rdata <= dm_addr ^ 16'h5A3C;
                end
            end
        end
    end
    // one-cycle transfer-end pulse
    task end_pulse;
        @(posedge clock);
        serial_end <= 1'b1;
        @(posedge clock);
        serial_end <= 1'b0;
    endtask
endmodule

// [tb/ettc_top_tb.sv]
`timescale 1ns/1ps
// self-checking bench of the transfer controller
module ettc_top_tb;
    reg          clock = 0;
    reg          rstn = 0;
    reg          hsel = 0;
    reg  [31:0]  haddr = 0;
    reg  [1:0]   htrans = 0;
    reg          hwrite = 0;
    reg  [31:0]  hwdata = 0;
    reg  [39:0]  evt = 0;
    wire         hreadyout, hresp, serial_end, dm_req, dm_we, dm_size, dm_ack, busy;
    wire [31:0]  hrdata;
    wire [15:0]  dm_addr, dm_wdata, dm_rdata;
    int          err_count = 0;
    int          comparisons = 0;
    logic [31:0] rd;
    // address, write data, readback
    logic [31:0] rows [8][3] = '{'{32'h00, 32'h08, 32'h08}, '{32'h04, 32'hA5, 32'hA5},
        '{32'h04, 32'h00, 32'h00}, '{32'h14, 32'hFFFF_FF5A, 32'h5A}, '{32'h14, 32'h00, 32'h00},
        '{32'h18, 32'hFD, 32'hFD}, '{32'h40, 32'h77, 32'h00}, '{32'h1C, 32'hFFF, 32'h00}};
    always #25 clock = ~clock;
    ettc_top ettc_top_i (.clock, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .evt, .serial_end, .dm_req, .dm_we, .dm_size,
        .dm_addr, .dm_wdata, .dm_rdata, .dm_ack, .busy);
    ettc_mover_model ettc_mover_model_i (.clock, .dm_req, .dm_we, .dm_addr, .dm_wdata, .dm_rdata,
        .dm_ack, .serial_end);
////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bounded, since a busy engine may stretch a control-area access
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (n > 400) begin
                err_count++;
                report_and_stop;
            end
        end while (hreadyout !== 1'b1);
    endtask
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready;
        rd = hrdata;
    endtask
    task rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task settle;
        int n;
        repeat (3) @(posedge clock);
        for (n = 0; busy !== 1'b0; n++) begin
            if (n > 400) begin
                err_count++;
                report_and_stop;
            end
            @(posedge clock);
        end
    endtask
    task exp_wr(input logic [15:0] a, input logic [15:0] d);
        if (ettc_mover_model_i.wa_q.size() == 0) chk("write count", 1, 0);
        else begin
            chk("write addr", a, ettc_mover_model_i.wa_q.pop_front());
            chk("write data", d, ettc_mover_model_i.wd_q.pop_front());
        end
    endtask
////////////////////////////////////////////////////////////////////////
    initial begin
        int k;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        for (k = 0; k < 8; k++) rdc("reset value", 32'(k * 4), k == 6 ? 32'hFD : 32'h0);
        for (k = 0; k < 8; k++) begin
            ahb(1'b1, rows[k][0], rows[k][1]);
            rdc("readback", rows[k][0], rows[k][2]);
        end
        // set three bytes into a buffer, chained to set four words in repeat
        ahb(1'b1, 32'h0000_FD18, 32'h0707_0118);
        ahb(1'b1, 32'h0000_FD1C, 32'hE900_FF10);
        ahb(1'b1, 32'h0000_FD20, 32'h0301_0245);
        ahb(1'b1, 32'h0000_FD24, 32'hFF10_E910);
        ahb(1'b1, 32'h08, 32'h08);
        // disabled source, then a stopped clock: both must stay quiet
        evt <= 40'h00_0000_1000;
        @(posedge clock);
        evt <= 40'h0;
        ahb(1'b1, 32'h00, 32'h00);
        ettc_mover_model_i.end_pulse;
        repeat (10) @(posedge clock);
        ahb(1'b1, 32'h00, 32'h08);
        repeat (5) @(posedge clock);
        chk("quiet writes", 0, ettc_mover_model_i.wa_q.size());
        chk("busy", 0, {31'h0, busy});
        for (k = 0; k < 7; k++) begin
            ettc_mover_model_i.end_pulse;
            settle;
            exp_wr(16'(16'hE900 + k), 16'h002C);
            exp_wr(16'hFF10, 16'((16'hE910 + 4 * k) ^ 16'h5A3C));
            exp_wr(16'hFF10, 16'((16'hE912 + 4 * k) ^ 16'h5A3C));
            if (k == 0) rdc("reload", 32'h0000_FD20, 32'h0303_0245);
        end
        rdc("enable cleared", 32'h08, 32'h00);
        rdc("set three", 32'h0000_FD18, 32'h0700_0118);
        rdc("pointers", 32'h0000_FD1C, 32'hE907_FF10);
        // reset in mid-run: registers written away from reset values return
        ahb(1'b1, 32'h18, 32'h55);
        ahb(1'b1, 32'h04, 32'h81);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        rdc("reset gate", 32'h00, 32'h00);
        rdc("reset enable", 32'h04, 32'h00);
        rdc("reset base", 32'h18, 32'hFD);
        report_and_stop;
    end
endmodule
